// File: rtl/trx_pkg.sv
// Constants and carrier types for the table-read transfer execution unit.
// Assumes a 10-bit instruction word and one instruction cycle per sys_clk
// edge on which instr_valid is high.
package trx_pkg;

   localparam int         INSTR_W        = 10;
   localparam int         PAGE_W         = 6;
   localparam int         PCL_W          = 7;
   localparam int         PC_W           = PAGE_W + PCL_W;
   localparam int         NIB_W          = 4;
   localparam int         DREG_W         = 3;
   localparam int         SP_W           = 3;
   localparam int         STACK_DEPTH    = 8;

   localparam logic [3:0] TABLE_OP_HI    = 4'h2;
   localparam int         TABLE_OP_LSB   = 6;
   localparam logic [9:0] PRESC_READ_OP  = 10'h275;
   localparam logic [9:0] SERIAL_READ_OP = 10'h278;
   localparam int         TABLE_CYCLES   = 3;
   localparam logic [5:0] PAGE_LIMIT     = 6'h1f;

   localparam int         ROM_D_HI       = 9;
   localparam int         ROM_D_LO       = 8;
   localparam int         ROM_B_HI       = 7;
   localparam int         ROM_B_LO       = 4;
   localparam int         ROM_A_HI       = 3;
   localparam int         ROM_A_LO       = 0;
   localparam int         DREG_CLR_BIT   = 2;

   localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
   localparam logic [SP_W-1:0]   SP_RESET  = 3'h7;
   localparam logic [NIB_W-1:0]  NIB_RESET = 4'h0;
   localparam logic [DREG_W-1:0] D_RESET   = 3'h0;

   typedef enum logic [1:0] {
      TRX_IDLE,
      TRX_FETCH,
      TRX_RESTORE
   } trx_state_t;

   // Working registers of the core touched by these instructions
   typedef struct packed {
      logic [NIB_W-1:0]  acc;
      logic [NIB_W-1:0]  breg;
      logic [DREG_W-1:0] dreg;
   } trx_regs_t;

   // Program memory fetch port
   typedef struct packed {
      logic            req;
      logic [PC_W-1:0] addr;
   } trx_rom_req_t;

endpackage

// File: rtl/trx_stack.sv
// Return stack: flip-flop storage addressed by the stack pointer.
// Assumes one push or read per cycle, written by the executing unit only.
`timescale 1ns/1ns
`default_nettype none

module trx_stack #(
   parameter int DEPTH = trx_pkg::STACK_DEPTH,
   parameter int WIDTH = trx_pkg::PC_W,
   parameter int AW    = trx_pkg::SP_W
) (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_idx,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [AW-1:0]    rd_idx,
   output logic      [WIDTH-1:0] rd_data
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
   } trx_stack_st_t;

   trx_stack_st_t st_ff;
   trx_stack_st_t nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      if (wr_en)
      begin
         nxt_st.mem[wr_idx] = wr_data;
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign rd_data = st_ff.mem[rd_idx];

endmodule

`default_nettype wire

// File: rtl/trx_exec.sv
// Execution unit for the table read, prescaler read and serial read
// instructions of a 4-bit core. Assumes the instruction word arrives with
// instr_valid for one cycle, and that ROM data is valid in the cycle that
// rom.req is high. busy holds off the next instruction during a table read.
`timescale 1ns/1ns
`default_nettype none

module trx_exec #(
   parameter int DEPTH = trx_pkg::STACK_DEPTH
) (
   input  wire logic                       sys_clk,
   input  wire logic                       reset,
   input  wire logic                       instr_valid,
   input  wire logic [trx_pkg::INSTR_W-1:0] instr,
   input  wire logic [trx_pkg::PC_W-1:0]   pc_in,
   input  wire logic [7:0]                 prescaler_count,
   input  wire logic [7:0]                 serial_shift,
   input  wire logic [trx_pkg::INSTR_W-1:0] rom_data,
   output trx_pkg::trx_rom_req_t           rom,
   output trx_pkg::trx_regs_t              regs,
   output logic [trx_pkg::PC_W-1:0]        pc_out,
   output logic                            pc_load,
   output logic [trx_pkg::SP_W-1:0]        stack_pointer,
   output logic                            page_range_err,
   output logic                            busy
);

   //----------------------------------------------------------------------
   // State
   //----------------------------------------------------------------------
   typedef struct packed {
      trx_pkg::trx_state_t   fsm;
      trx_pkg::trx_regs_t    regs;
      logic [trx_pkg::SP_W-1:0] sp;
      logic [trx_pkg::PC_W-1:0] pc;
      logic                  pc_load;
      trx_pkg::trx_rom_req_t rom;
      logic                  page_err;
   } trx_st_t;

   trx_st_t st_ff;
   trx_st_t nxt_st;

   logic                     is_table;
   logic                     is_presc;
   logic                     is_serial;
   logic                     push_en;
   logic [trx_pkg::PC_W-1:0] stack_rd;

   //----------------------------------------------------------------------
   // Decode
   //----------------------------------------------------------------------
   assign is_table  = instr[trx_pkg::INSTR_W-1:trx_pkg::TABLE_OP_LSB]
                      == trx_pkg::TABLE_OP_HI;
   assign is_presc  = instr == trx_pkg::PRESC_READ_OP;
   assign is_serial = instr == trx_pkg::SERIAL_READ_OP;
   assign push_en   = instr_valid && is_table
                      && (st_ff.fsm == trx_pkg::TRX_IDLE);

   trx_stack #(
      .DEPTH   (DEPTH),
      .WIDTH   (trx_pkg::PC_W),
      .AW      (trx_pkg::SP_W)
   ) u_return_stack (
      .sys_clk (sys_clk),
      .reset   (reset),
      .wr_en   (push_en),
      .wr_idx  (st_ff.sp + 3'h1),
      .wr_data (pc_in),
      .rd_idx  (st_ff.sp),
      .rd_data (stack_rd)
   );

   //----------------------------------------------------------------------
   // Next state
   //----------------------------------------------------------------------
   always_comb
   begin
      nxt_st         = st_ff;
      nxt_st.pc_load = 1'b0;
      nxt_st.rom.req = 1'b0;
      unique case (st_ff.fsm)
         trx_pkg::TRX_IDLE:
         begin
            if (instr_valid && is_table)
            begin
               // Cycle 1: push PC, form table address
               nxt_st.sp       = st_ff.sp + 3'h1;
               nxt_st.rom.addr = {instr[trx_pkg::PAGE_W-1:0],
                                  st_ff.regs.dreg,
                                  st_ff.regs.acc};
               nxt_st.rom.req  = 1'b1;
               nxt_st.page_err = instr[trx_pkg::PAGE_W-1:0]
                                 > trx_pkg::PAGE_LIMIT;
               nxt_st.fsm      = trx_pkg::TRX_FETCH;
            end
            else if (instr_valid && is_presc)
            begin
               nxt_st.regs.breg = prescaler_count[7:4];
               nxt_st.regs.acc  = prescaler_count[3:0];
            end
            else if (instr_valid && is_serial)
            begin
               nxt_st.regs.breg = serial_shift[7:4];
               nxt_st.regs.acc  = serial_shift[3:0];
            end
         end
         trx_pkg::TRX_FETCH:
         begin
            // Cycle 2: ROM word lands in D, B and A
            nxt_st.regs.dreg[trx_pkg::DREG_CLR_BIT] = 1'b0;
            nxt_st.regs.dreg[1:0] =
               rom_data[trx_pkg::ROM_D_HI:trx_pkg::ROM_D_LO];
            nxt_st.regs.breg =
               rom_data[trx_pkg::ROM_B_HI:trx_pkg::ROM_B_LO];
            nxt_st.regs.acc  =
               rom_data[trx_pkg::ROM_A_HI:trx_pkg::ROM_A_LO];
            nxt_st.fsm       = trx_pkg::TRX_RESTORE;
         end
         trx_pkg::TRX_RESTORE:
         begin
            // Cycle 3: restore PC from stack, then pop
            nxt_st.pc      = stack_rd;
            nxt_st.pc_load = 1'b1;
            nxt_st.sp      = st_ff.sp - 3'h1;
            nxt_st.fsm     = trx_pkg::TRX_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         st_ff.fsm      <= trx_pkg::TRX_IDLE;
         st_ff.regs     <= '{acc:  trx_pkg::NIB_RESET,
                             breg: trx_pkg::NIB_RESET,
                             dreg: trx_pkg::D_RESET};
         st_ff.sp       <= trx_pkg::SP_RESET;
         st_ff.pc       <= trx_pkg::PC_RESET;
         st_ff.pc_load  <= 1'b0;
         st_ff.rom      <= '0;
         st_ff.page_err <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   //----------------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------------
   assign rom            = st_ff.rom;
   assign regs           = st_ff.regs;
   assign pc_out         = st_ff.pc;
   assign pc_load        = st_ff.pc_load;
   assign stack_pointer  = st_ff.sp;
   assign page_range_err = st_ff.page_err;
   assign busy           = st_ff.fsm != trx_pkg::TRX_IDLE;

endmodule

`default_nettype wire

// File: tb/trx_rom_model.sv
// Program memory model answering the execution unit's fetch port.
// Assumes the word is sampled while rom.req is high.
`timescale 1ns/1ns
`default_nettype none

module trx_rom_model (
   input  wire logic               sys_clk,
   input  wire logic               reset,
   input  wire trx_pkg::trx_rom_req_t rom,
   output logic [9:0]              rom_data
);
   logic [9:0] junk_ff;

   // Between fetches the bus toggles so stale data never looks valid
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         junk_ff <= 10'h155;
      else
         junk_ff <= ~junk_ff;
   end

   assign rom_data = rom.req ?
      ((rom.addr[9:0] ^ 10'h35a) + {7'h00, rom.addr[12:10]}) : junk_ff;
endmodule
`default_nettype wire

// File: tb/trx_exec_checker.sv
// Concurrent checks on the execution unit's ports.
// Assumes reset is asynchronous and active high.
`timescale 1ns/1ns
`default_nettype none

module trx_exec_checker #(
   parameter int DEPTH = trx_pkg::STACK_DEPTH
) (
   input wire logic                        sys_clk,
   input wire logic                        reset,
   input wire logic                        instr_valid,
   input wire logic [trx_pkg::INSTR_W-1:0] instr,
   input wire logic [trx_pkg::PC_W-1:0]    pc_in,
   input wire logic [7:0]                  prescaler_count,
   input wire logic [7:0]                  serial_shift,
   input wire logic [trx_pkg::INSTR_W-1:0] rom_data,
   input wire trx_pkg::trx_rom_req_t       rom,
   input wire trx_pkg::trx_regs_t          regs,
   input wire logic [trx_pkg::PC_W-1:0]    pc_out,
   input wire logic                        pc_load,
   input wire logic [trx_pkg::SP_W-1:0]    stack_pointer,
   input wire logic                        page_range_err,
   input wire logic                        busy
);
   logic tab_go;
   logic go_ok;

   assign go_ok  = instr_valid && !busy;
   assign tab_go = go_ok && instr[9:6] == trx_pkg::TABLE_OP_HI;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_hold; busy ##1 busy; endsequence
   sequence s_ret; !busy && pc_load; endsequence

   AST_TABLE_LEN: assert property (tab_go |=> s_hold ##1 s_ret)
      else $error("table read length wrong");
   AST_ROM_ADDR: assert property (tab_go |=> rom.req && rom.addr ==
      {$past(instr[5:0]), $past(regs.dreg), $past(regs.acc)})
      else $error("fetch address wrong");
   AST_DREG: assert property (rom.req |=>
      regs.dreg == {1'b0, $past(rom_data[9:8])})
      else $error("D load wrong");
   AST_BA: assert property (rom.req |=> regs.breg == $past(rom_data[7:4])
      && regs.acc == $past(rom_data[3:0]))
      else $error("B or A load wrong");
   AST_STACK: assert property (tab_go |=>
      stack_pointer == $past(stack_pointer) + 3'h1 ##2
      (stack_pointer == $past(stack_pointer, 3) && pc_out == $past(pc_in, 3)))
      else $error("stack use wrong");
   AST_PRESC: assert property (go_ok && instr == trx_pkg::PRESC_READ_OP |=>
      regs.breg == $past(prescaler_count[7:4]) && !busy
      && regs.acc == $past(prescaler_count[3:0]))
      else $error("prescaler read wrong");
   AST_SERIAL: assert property (go_ok && instr == trx_pkg::SERIAL_READ_OP |=>
      regs.breg == $past(serial_shift[7:4]) && !busy
      && regs.acc == $past(serial_shift[3:0]))
      else $error("serial read wrong");
   AST_PAGE_ERR: assert property (tab_go |=>
      page_range_err == ($past(instr[5:0]) > trx_pkg::PAGE_LIMIT))
      else $error("page flag wrong");
endmodule

bind trx_exec trx_exec_checker #(.DEPTH(DEPTH)) trx_exec_checker_inst (
   .sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
   .instr(instr), .pc_in(pc_in), .prescaler_count(prescaler_count),
   .serial_shift(serial_shift), .rom_data(rom_data), .rom(rom),
   .regs(regs), .pc_out(pc_out), .pc_load(pc_load),
   .stack_pointer(stack_pointer), .page_range_err(page_range_err),
   .busy(busy));
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the table read transfer execution unit.
// Assumes the ROM model answers while rom.req is high.
`timescale 1ns/1ns
`default_nettype none

module testbench;
   logic sys_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, pc_load;
   logic [9:0] instr = 10'h000, rom_data;
   logic [12:0] pc_in = 13'h0000, pc_out;
   logic [7:0] prescaler_count = 8'h00, serial_shift = 8'h00;
   logic [2:0] stack_pointer, exp_d;
   logic page_range_err, busy;
   logic [3:0] exp_a, exp_b;
   trx_pkg::trx_rom_req_t rom;
   trx_pkg::trx_regs_t regs;
   int fail_count = 0, checks = 0;

   trx_exec trx_exec_inst (.sys_clk(sys_clk), .reset(reset),
      .instr_valid(instr_valid), .instr(instr), .pc_in(pc_in),
      .prescaler_count(prescaler_count), .serial_shift(serial_shift),
      .rom_data(rom_data), .rom(rom), .regs(regs), .pc_out(pc_out),
      .pc_load(pc_load), .stack_pointer(stack_pointer),
      .page_range_err(page_range_err), .busy(busy));
   trx_rom_model trx_rom_model_inst (.sys_clk(sys_clk), .reset(reset),
      .rom(rom), .rom_data(rom_data));

   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic chk(input string name, input logic [15:0] seen,
                      input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         fail_count++;
      end
   endtask

   task automatic test_done();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic issue(input logic [9:0] op);
      instr_valid = 1'b1;
      instr = op;
      @(posedge sys_clk);
      #10;
   endtask

   task automatic t_reset();
      instr_valid = 1'b0;
      reset = 1'b1;
      repeat (5) @(posedge sys_clk);
      #10;
      reset = 1'b0;
      exp_a = 4'h0;
      exp_b = 4'h0;
      exp_d = 3'h0;
      chk("regs", regs, 16'h0000);
      chk("sp", stack_pointer, 16'h0007);
      chk("busy_load", {busy, pc_load, rom.req}, 16'h0000);
   endtask

   task automatic t_byte(input logic ser, input logic [7:0] v);
      prescaler_count = ser ? 8'h00 : v;
      serial_shift = ser ? v : 8'hff;
      issue(ser ? trx_pkg::SERIAL_READ_OP : trx_pkg::PRESC_READ_OP);
      exp_b = v[7:4];
      exp_a = v[3:0];
      chk("byte_regs", regs, {exp_a, exp_b, exp_d});
      chk("byte_busy", {busy, rom.req}, 16'h0000);
   endtask

   task automatic t_table(input logic [5:0] page, input logic [12:0] pc,
                          input logic refuse);
      logic [12:0] a;
      logic [9:0] w;
      pc_in = pc;
      serial_shift = 8'hff;
      issue({trx_pkg::TABLE_OP_HI, page});
      instr_valid = refuse;
      instr = trx_pkg::SERIAL_READ_OP;
      a = {page, exp_d, exp_a};
      w = (a[9:0] ^ 10'h35a) + {7'h00, a[12:10]};
      chk("rom_req", {rom.req, busy}, 16'h0003);
      chk("rom_addr", rom.addr, a);
      chk("sp_push", stack_pointer, 16'h0000);
      @(posedge sys_clk);
      #10;
      instr_valid = 1'b0;
      exp_d = {1'b0, w[9:8]};
      exp_b = w[7:4];
      exp_a = w[3:0];
      chk("d_reg", regs.dreg, exp_d);
      chk("ba", {regs.breg, regs.acc}, {exp_b, exp_a});
      chk("page_err", page_range_err, page > 6'h1f);
      @(posedge sys_clk);
      #10;
      chk("restore", {busy, pc_load, pc_out}, {2'b01, pc});
      chk("sp_pop", stack_pointer, 16'h0007);
      chk("kept", regs, {exp_a, exp_b, exp_d});
   endtask

   initial
   begin
      #2000000;
      fail_count++;
      test_done();
   end

   initial
   begin
      t_reset();
      t_byte(1'b0, 8'ha5);
      t_table(6'h00, 13'h0123, 1'b0);
      t_table(6'h1f, 13'h1abc, 1'b1);
      t_byte(1'b1, 8'h3c);
      t_byte(1'b0, 8'hc3);
      instr_valid = 1'b0;
      @(posedge sys_clk);
      #10;
      t_table(6'h20, 13'h0fff, 1'b0);
      t_table(6'h0a, 13'h0001, 1'b0);
      t_byte(1'b1, 8'h96);
      t_reset();
      test_done();
   end
endmodule
`default_nettype wire
